//--- logic/smcg_map.svh
`ifndef SMCG_MAP_SVH
`define SMCG_MAP_SVH
// =====================================================================
// register byte addresses
`define SMCG_ADDR_PIN_CTRL   8'h00
`define SMCG_ADDR_PWR_ONE    8'h04
`define SMCG_ADDR_PWR_THREE  8'h08
`define SMCG_ADDR_GATE_ONE   8'h0C
`define SMCG_ADDR_GATE_TWO   8'h10
`define SMCG_ADDR_RST_CAUSE  8'h14
`define SMCG_ADDR_STATUS     8'h18
// =====================================================================
// ext_request_pin_ctrl_status bits
`define SMCG_PIN_MODE_BIT    0
`define SMCG_PIN_IE_BIT      1
`define SMCG_PIN_ACK_BIT     2
`define SMCG_PIN_FLAG_BIT    3
`define SMCG_PIN_FE_BIT      4
`define SMCG_PIN_POL_BIT     5
`define SMCG_PIN_PDD_BIT     6
// power_mgmt_ctrl_one bits
`define SMCG_P1_ACK_BIT      6
`define SMCG_P1_FLAG_BIT     7
`define SMCG_P1_IE_BIT       5
`define SMCG_P1_RE_BIT       4
`define SMCG_P1_SE_BIT       3
`define SMCG_P1_EN_BIT       2
// power_mgmt_ctrl_three bits
`define SMCG_P3_FLAG_BIT     7
`define SMCG_P3_ACK_BIT      6
`define SMCG_P3_IE_BIT       5
// reset_cause_status bits
`define SMCG_RC_POR_BIT      7
`define SMCG_RC_LVD_BIT      1
// reset values
`define SMCG_RST_PIN_CTRL    8'h00
`define SMCG_RST_PWR_ONE     8'h1C
`define SMCG_RST_GATE        8'hFF
`define SMCG_RST_CAUSE_POR   8'h82
`endif

//--- logic/smcg_pkg.sv
package smcg_pkg;
   typedef enum logic [2:0] {
      SMCG_RUN = 3'b001,
      SMCG_STOP2 = 3'b010,
      SMCG_STOP3 = 3'b100
   } smcg_mode_t;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } smcg_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } smcg_axi_rsp_t;

   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] pin_ctrl;
      logic [7:0] pwr_one;
      logic [7:0] pwr_three;
      logic [7:0] gate_one;
      logic [7:0] gate_two;
      logic [7:0] rst_cause;
      logic pin_s1;
      logic pin_s2;
      logic pin_prev;
      logic low_s1;
      logic low_s2;
      logic warn_s1;
      logic warn_s2;
      logic por_s1;
      logic por_s2;
      logic bo_reset;
      logic stop_s1;
      logic stop_s2;
      smcg_mode_t mode;
   } smcg_state_t;
endpackage

//--- logic/smcg_top.sv
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "smcg_map.svh"
// Functional notes
// - monitor runs when enabled, stop needs stop-enable
// - enable plus stop-enable picks stop3
// - power-on holds reset until supply good
// - power-on sets power-on and brown-out causes
// - reset-enable: low supply resets, cause set
// - interrupt mode: low supply sets flag, requests
// - brown-out acknowledge clears brown-out flag
// - warning flag set, interrupt when enabled
// - warning acknowledge clears warning flag
// - all peripheral clocks enabled after reset
// - gating writes take effect right after
// - writes to gated peripherals are dropped
// - stop modes remove all gated clocks
// - bit 6 disables internal pull device
// - bit 5 polarity, high selects pulldown
// - bit 4 enables pin request function
// - bit 3 read-only request flag
// - bit 2 write-one acknowledge, reads zero
// - level mode: no clear while asserted
// - bit 1 gates request onto interrupt
// - bit 0 selects edge or edge-level
module smcg_top #(
   parameter int GATE_WIDTH = 16
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input smcg_pkg::smcg_axi_req_t axi_req,
   output smcg_pkg::smcg_axi_rsp_t axi_rsp,
   input wire logic ext_pin,
   input wire logic supply_below_detect,
   input wire logic supply_warning,
   input wire logic supply_below_por,
   input wire logic stop_request,
   input wire logic [GATE_WIDTH-1:0] periph_write_req,
   output logic [GATE_WIDTH-1:0] periph_write_ok,
   output logic [GATE_WIDTH-1:0] periph_clk_en,
   output logic monitor_active,
   output logic device_reset,
   output logic [2:0] power_mode,
   output logic pull_enable,
   output logic pull_down,
   output logic ext_request_irq,
   output logic supply_irq
);
   import smcg_pkg::*;

   smcg_state_t s;
   smcg_state_t next_s;
   logic [15:0] gates;

   // =====================================================================
   // clock gating outputs
   assign gates = {s.gate_two, s.gate_one};
   genvar gi;
   generate
      for (gi = 0; gi < GATE_WIDTH; gi++)
      begin : g_gate
         // stop removes every gated clock regardless of setting
         assign periph_clk_en[gi] = gates[gi % 16] && (s.mode == SMCG_RUN);
         // gated-off peripheral ignores writes, software must reinit
         assign periph_write_ok[gi] = periph_write_req[gi] && periph_clk_en[gi];
      end
   endgenerate

   // =====================================================================
   // misc outputs
   assign monitor_active = s.pwr_one[`SMCG_P1_EN_BIT] &&
      ((s.mode == SMCG_RUN) || s.pwr_one[`SMCG_P1_SE_BIT]);
   assign device_reset = s.por_s2 || s.bo_reset;
   assign power_mode = s.mode;
   assign pull_enable = s.pin_ctrl[`SMCG_PIN_FE_BIT] && !s.pin_ctrl[`SMCG_PIN_PDD_BIT];
   assign pull_down = pull_enable && s.pin_ctrl[`SMCG_PIN_POL_BIT];
   assign ext_request_irq = s.pin_ctrl[`SMCG_PIN_FLAG_BIT] && s.pin_ctrl[`SMCG_PIN_IE_BIT];
   assign supply_irq = (s.pwr_one[`SMCG_P1_FLAG_BIT] && s.pwr_one[`SMCG_P1_IE_BIT]) ||
      (s.pwr_three[`SMCG_P3_FLAG_BIT] && s.pwr_three[`SMCG_P3_IE_BIT]);

   always_comb
   begin
      // masked while frozen, else a stalled cycle would swallow a handshake
      axi_rsp.awready = !s.aw_held && clk_en;
      axi_rsp.wready = !s.w_held && clk_en;
      axi_rsp.bvalid = s.bvalid && clk_en;
      axi_rsp.bresp = s.bresp;
      axi_rsp.arready = !s.rvalid && clk_en;
      axi_rsp.rvalid = s.rvalid && clk_en;
      axi_rsp.rdata = s.rdata;
      axi_rsp.rresp = s.rresp;
   end

   // =====================================================================
   // next state
   always_comb
   begin
      logic pin_active;
      logic pin_edge;
      logic wr_go;
      logic low_now;
      logic [7:0] wd;
      next_s = s;
      pin_active = 1'b0;
      pin_edge = 1'b0;
      wr_go = 1'b0;
      low_now = 1'b0;
      wd = 8'h00;

      // two-stage synchronisers on the pin, supply and stop inputs
      next_s.pin_s1 = ext_pin;
      next_s.pin_s2 = s.pin_s1;
      next_s.pin_prev = s.pin_s2;
      next_s.low_s1 = supply_below_detect;
      next_s.low_s2 = s.low_s1;
      next_s.warn_s1 = supply_warning;
      next_s.warn_s2 = s.warn_s1;
      next_s.por_s1 = supply_below_por;
      next_s.por_s2 = s.por_s1;
      next_s.stop_s1 = stop_request;
      next_s.stop_s2 = s.stop_s1;

      // stop entry and exit
      if (s.stop_s2 && s.mode == SMCG_RUN)
      begin
         if (s.pwr_one[`SMCG_P1_EN_BIT] && s.pwr_one[`SMCG_P1_SE_BIT])
            next_s.mode = SMCG_STOP3;
         else
            next_s.mode = SMCG_STOP2;
      end
      else if (!s.stop_s2)
         next_s.mode = SMCG_RUN;

      // supply monitor
      low_now = monitor_active && s.low_s2;
      if (s.por_s2)
      begin
         next_s.rst_cause = `SMCG_RST_CAUSE_POR;
         next_s.bo_reset = 1'b1; // hold until above detect threshold
      end
      else if (s.bo_reset)
      begin
         if (!s.low_s2)
            next_s.bo_reset = 1'b0;
      end
      else if (low_now && s.pwr_one[`SMCG_P1_RE_BIT])
      begin
         next_s.bo_reset = 1'b1;
         // power-on cause survives a brown-out reset
         next_s.rst_cause[6:0] = 7'h00;
         next_s.rst_cause[`SMCG_RC_LVD_BIT] = 1'b1;
      end

      // =====================================================================
      // bus write path: address and data in either order
      if (axi_req.awvalid && !s.aw_held)
      begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !s.w_held)
      begin
         next_s.w_held = 1'b1;
         next_s.w_data = axi_req.wdata;
         next_s.w_strb = axi_req.wstrb;
      end
      if (s.bvalid && axi_req.bready)
         next_s.bvalid = 1'b0;
      wr_go = s.aw_held && s.w_held && !s.bvalid;
      wd = s.w_data[7:0];

      // acknowledges clear first so that a same-cycle set wins below
      if (wr_go)
      begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = 2'b00;
         if (!s.w_strb[0])
            ;
         else
         begin
            unique case (s.aw_addr)
               `SMCG_ADDR_PIN_CTRL:
               begin
                  next_s.pin_ctrl[`SMCG_PIN_PDD_BIT] = wd[`SMCG_PIN_PDD_BIT];
                  next_s.pin_ctrl[`SMCG_PIN_POL_BIT] = wd[`SMCG_PIN_POL_BIT];
                  next_s.pin_ctrl[`SMCG_PIN_FE_BIT] = wd[`SMCG_PIN_FE_BIT];
                  next_s.pin_ctrl[`SMCG_PIN_IE_BIT] = wd[`SMCG_PIN_IE_BIT];
                  next_s.pin_ctrl[`SMCG_PIN_MODE_BIT] = wd[`SMCG_PIN_MODE_BIT];
                  if (wd[`SMCG_PIN_ACK_BIT])
                     next_s.pin_ctrl[`SMCG_PIN_FLAG_BIT] = 1'b0;
               end
               `SMCG_ADDR_PWR_ONE:
               begin
                  next_s.pwr_one[5:2] = wd[5:2];
                  if (wd[`SMCG_P1_ACK_BIT])
                     next_s.pwr_one[`SMCG_P1_FLAG_BIT] = 1'b0;
               end
               `SMCG_ADDR_PWR_THREE:
               begin
                  next_s.pwr_three[`SMCG_P3_IE_BIT] = wd[`SMCG_P3_IE_BIT];
                  if (wd[`SMCG_P3_ACK_BIT])
                     next_s.pwr_three[`SMCG_P3_FLAG_BIT] = 1'b0;
               end
               `SMCG_ADDR_GATE_ONE: next_s.gate_one = wd;
               `SMCG_ADDR_GATE_TWO: next_s.gate_two = wd;
               `SMCG_ADDR_RST_CAUSE, `SMCG_ADDR_STATUS: ;
               default: next_s.bresp = 2'b10;
            endcase
         end
      end

      // =====================================================================
      // flag sets, after clears
      if (low_now && !s.pwr_one[`SMCG_P1_RE_BIT] && s.pwr_one[`SMCG_P1_IE_BIT])
         next_s.pwr_one[`SMCG_P1_FLAG_BIT] = 1'b1;
      if (s.warn_s2 && !s.low_s2 && monitor_active)
         next_s.pwr_three[`SMCG_P3_FLAG_BIT] = 1'b1;

      // polarity 1 means rising or high
      pin_active = s.pin_s2 ~^ s.pin_ctrl[`SMCG_PIN_POL_BIT];
      pin_edge = pin_active && !(s.pin_prev ~^ s.pin_ctrl[`SMCG_PIN_POL_BIT]);
      if (s.pin_ctrl[`SMCG_PIN_FE_BIT])
      begin
         if (pin_edge || (s.pin_ctrl[`SMCG_PIN_MODE_BIT] && pin_active))
            next_s.pin_ctrl[`SMCG_PIN_FLAG_BIT] = 1'b1;
      end
      next_s.pin_ctrl[`SMCG_PIN_ACK_BIT] = 1'b0;
      next_s.pin_ctrl[7] = 1'b0;

      // =====================================================================
      // bus read path
      if (s.rvalid && axi_req.rready)
         next_s.rvalid = 1'b0;
      if (axi_req.arvalid && !s.rvalid)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp = 2'b00;
         next_s.rdata = 32'h0000_0000;
         unique case (axi_req.araddr)
            `SMCG_ADDR_PIN_CTRL: next_s.rdata[7:0] = s.pin_ctrl;
            `SMCG_ADDR_PWR_ONE: next_s.rdata[7:0] = {s.pwr_one[7], 1'b0, s.pwr_one[5:0]};
            `SMCG_ADDR_PWR_THREE: next_s.rdata[7:0] = {s.pwr_three[7], 1'b0, s.pwr_three[5:0]};
            `SMCG_ADDR_GATE_ONE: next_s.rdata[7:0] = s.gate_one;
            `SMCG_ADDR_GATE_TWO: next_s.rdata[7:0] = s.gate_two;
            `SMCG_ADDR_RST_CAUSE: next_s.rdata[7:0] = s.rst_cause;
            `SMCG_ADDR_STATUS: next_s.rdata[7:0] = {5'b0_0000, s.mode};
            default: next_s.rresp = 2'b10;
         endcase
      end
   end

   // =====================================================================
   // state register, frozen while clk_en low
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s <= '0;
         s.pin_ctrl <= `SMCG_RST_PIN_CTRL;
         s.pwr_one <= `SMCG_RST_PWR_ONE;
         s.gate_one <= `SMCG_RST_GATE;
         s.gate_two <= `SMCG_RST_GATE;
         s.rst_cause <= `SMCG_RST_CAUSE_POR;
         s.mode <= SMCG_RUN;
      end
      else if (clk_en)
         s <= next_s;
   end
endmodule // smcg_top

//--- verification/smcg_checker.sv
`timescale 1ns/10ps
// ==========
// port checker
module smcg_checker
import smcg_pkg::*;
#(parameter int GATE_WIDTH = 16)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input smcg_pkg::smcg_axi_rsp_t axi_rsp,
   input wire logic supply_below_detect,
   input wire logic supply_below_por,
   input wire logic [GATE_WIDTH-1:0] periph_write_req,
   input logic [GATE_WIDTH-1:0] periph_write_ok,
   input logic [GATE_WIDTH-1:0] periph_clk_en,
   input logic monitor_active,
   input logic device_reset,
   input logic [2:0] power_mode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_wr_ok; periph_write_ok == (periph_write_req & periph_clk_en); endproperty
   a_wr_ok: assert property (p_wr_ok) else $error("write reached gated peripheral");
   property p_stop_gate; power_mode != 3'b001 |-> periph_clk_en == '0; endproperty
   a_stop_gate: assert property (p_stop_gate) else $error("clock on in stop");
   property p_stop3; power_mode == 3'b100 |-> monitor_active; endproperty
   a_stop3: assert property (p_stop3) else $error("stop3 without monitor");
   property p_stop2; power_mode == 3'b010 |-> !monitor_active; endproperty
   a_stop2: assert property (p_stop2) else $error("monitor on in stop2");
   property p_por; supply_below_por [*3] |-> device_reset; endproperty
   a_por: assert property (p_por) else $error("no reset on power-on");
   // sync depth of two: release must trace back to a good supply
   property p_hold;
      $fell(device_reset) |-> !$past(supply_below_detect, 2) && !$past(supply_below_por, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("reset released early");
   property p_gate_src;
      $changed(periph_clk_en) |-> $changed(power_mode) || $rose(axi_rsp.bvalid);
   endproperty
   a_gate_src: assert property (p_gate_src) else $error("gate moved without write");
   property p_gate_rst; $past(sys_rst) |-> periph_clk_en == '1; endproperty
   a_gate_rst: assert property (p_gate_rst) else $error("gates off after reset");
endmodule // smcg_checker

bind smcg_top smcg_checker #(.GATE_WIDTH(GATE_WIDTH)) i_smcg_checker(.mclk(mclk),
   .sys_rst(sys_rst), .axi_rsp(axi_rsp), .supply_below_detect(supply_below_detect),
   .supply_below_por(supply_below_por), .periph_write_req(periph_write_req),
   .periph_write_ok(periph_write_ok), .periph_clk_en(periph_clk_en),
   .monitor_active(monitor_active), .device_reset(device_reset), .power_mode(power_mode));

//--- verification/smcg_pin_src.sv
`timescale 1ns/10ps
// ==========
// external request source, prompt or lagging by three cycles
module smcg_pin_src
(
   input wire logic mclk,
   input wire logic assert_pin,
   input wire logic active_high,
   input wire logic slow,
   output logic ext_pin
);
   logic [2:0] dly = 3'h0;
   always @(posedge mclk) dly <= {dly[1:0], assert_pin};
   assign ext_pin = (slow ? dly[2] : assert_pin) ~^ active_high;
endmodule // smcg_pin_src

//--- verification/smcg_bench.sv
`timescale 1ns/10ps
module smcg_bench;
import smcg_pkg::*;
   logic mclk = 0, sys_rst = 1, sbd = 0, swarn = 0, spor = 0, stp = 0;
   logic pon = 0, phi = 0, pslow = 0, epin, mact, drst, pen, pdn, eirq, sirq;
   logic [15:0] pwr = '0, pok, pce;
   logic [2:0] pmode;
   smcg_axi_req_t req = '0;
   smcg_axi_rsp_t rsp;
   int num_errors = 0, cmp_count = 0, cyc = 0;
   logic [1:0] bresp_seen = 2'b00;
   always #25 mclk = ~mclk;
   smcg_pin_src i_smcg_pin_src(.mclk(mclk), .assert_pin(pon), .active_high(phi),
      .slow(pslow), .ext_pin(epin));
   smcg_top #(.GATE_WIDTH(16)) i_smcg_top(.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
      .axi_req(req), .axi_rsp(rsp), .ext_pin(epin), .supply_below_detect(sbd),
      .supply_warning(swarn), .supply_below_por(spor), .stop_request(stp),
      .periph_write_req(pwr), .periph_write_ok(pok), .periph_clk_en(pce),
      .monitor_active(mact), .device_reset(drst), .power_mode(pmode), .pull_enable(pen),
      .pull_down(pdn), .ext_request_irq(eirq), .supply_irq(sirq));
   // ==========
   // bus and compare tasks
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic ad, dd;
      ad = 0;
      dd = 0;
      @(posedge mclk);
      req <= {1'b1, a, 1'b1, 24'h00_0000, d, 4'hF, 1'b1, req.arvalid, req.araddr, req.rready};
      while (!(ad && dd))
      begin
         @(posedge mclk);
         ad = ad | rsp.awready;
         dd = dd | rsp.wready;
         req.awvalid <= !ad;
         req.wvalid <= !dd;
      end
      while (!rsp.bvalid) @(posedge mclk);
      bresp_seen = rsp.bresp;
      req.bready <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
      @(posedge mclk);
      req.arvalid <= 1;
      req.araddr <= a;
      req.rready <= 1;
      @(posedge mclk);
      while (!rsp.arready) @(posedge mclk);
      req.arvalid <= 0;
      @(posedge mclk);
      while (!rsp.rvalid) @(posedge mclk);
      req.rready <= 0;
      chk(rsp.rdata, {24'h00_0000, e});
      chk(rsp.rresp, r);
   endtask
   // ==========
   // scenarios
   task t_regs;
      chk(pce, 16'hFFFF);
      rd(8'h00, 8'h00, 2'b00);
      rd(8'h04, 8'h1C, 2'b00);
      rd(8'h0C, 8'hFF, 2'b00);
      wr(8'h14, 8'h00);
      chk(bresp_seen, 2'b00);
      rd(8'h14, 8'h82, 2'b00);
      rd(8'h40, 8'h00, 2'b10);
      wr(8'h40, 8'h55);
      chk(bresp_seen, 2'b10);
   endtask
   task t_gate;
      // write requests go to all 16 peripherals, only the 4 still clocked get through
      wr(8'h0C, 8'h0F);
      chk(pce, 16'hFF0F);
      wr(8'h10, 8'h00);
      chk(pce, 16'h000F);
      pwr <= 16'hFFFF;
      @(posedge mclk);
      chk(pok, 16'h000F);
      pwr <= 16'h0000;
      wr(8'h0C, 8'hFF);
      wr(8'h10, 8'hFF);
   endtask
   task t_stop;
      stp <= 1;
      idle(6);
      chk({pmode, mact, pce}, {3'b100, 1'b1, 16'h0000});
      rd(8'h18, 8'h04, 2'b00);
      stp <= 0;
      wr(8'h04, 8'h14);
      stp <= 1;
      idle(6);
      chk({pmode, mact, pce}, {3'b010, 1'b0, 16'h0000});
      rd(8'h18, 8'h02, 2'b00);
      stp <= 0;
      idle(6);
      chk({pmode, pce}, {3'b001, 16'hFFFF});
   endtask
   task t_supply;
      wr(8'h04, 8'h24);
      sbd <= 1;
      idle(6);
      chk(sirq, 1);
      rd(8'h04, 8'hA4, 2'b00);
      sbd <= 0;
      wr(8'h04, 8'h64);
      rd(8'h04, 8'h24, 2'b00);
      wr(8'h08, 8'h20);
      swarn <= 1;
      idle(6);
      chk(sirq, 1);
      rd(8'h08, 8'hA0, 2'b00);
      swarn <= 0;
      wr(8'h08, 8'h60);
      rd(8'h08, 8'h20, 2'b00);
      chk(sirq, 0);
   endtask
   task t_reset;
      wr(8'h04, 8'h14);
      sbd <= 1;
      idle(6);
      chk(drst, 1);
      sbd <= 0;
      idle(6);
      chk(drst, 0);
      rd(8'h14, 8'h82, 2'b00);
      spor <= 1;
      sbd <= 1;
      idle(6);
      chk(drst, 1);
      spor <= 0;
      idle(6);
      chk(drst, 1);
      sbd <= 0;
      idle(6);
      chk(drst, 0);
   endtask
   task t_pin;
      wr(8'h00, 8'h12);
      chk({pen, pdn}, 2'b10);
      pon <= 1;
      idle(4);
      chk(eirq, 1);
      rd(8'h00, 8'h1A, 2'b00);
      wr(8'h00, 8'h16);
      rd(8'h00, 8'h12, 2'b00);
      wr(8'h00, 8'h10);
      pon <= 0;
      idle(4);
      pon <= 1;
      idle(4);
      rd(8'h00, 8'h18, 2'b00);
      chk(eirq, 0);
      // let the slow model drain before flipping the idle level
      pon <= 0;
      idle(4);
      pslow <= 1;
      phi <= 1;
      idle(4);
      wr(8'h00, 8'h37);
      rd(8'h00, 8'h33, 2'b00);
      chk({pen, pdn}, 2'b11);
      pon <= 1;
      idle(8);
      wr(8'h00, 8'h37);
      rd(8'h00, 8'h3B, 2'b00);
      pon <= 0;
      idle(8);
      wr(8'h00, 8'h77);
      rd(8'h00, 8'h73, 2'b00);
      chk(pen, 0);
      wr(8'h00, 8'h02);
      pon <= 1;
      idle(8);
      pon <= 0;
      idle(8);
      rd(8'h00, 8'h02, 2'b00);
   endtask
   // ==========
   // run control
   task summarize;
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         num_errors++;
         summarize();
      end
   end
   initial
   begin
      idle(12);
      sys_rst <= 0;
      t_regs();
      t_gate();
      t_stop();
      t_supply();
      t_reset();
      t_pin();
      summarize();
   end
endmodule // smcg_bench
